// ---- core/dbsc_top.v ----
// Self-test signature compressors, full-scale code and analog trim
// registers, reached over a four-wire serial port.
// Assumes the sample source forwards a DDR data clock with the data
// eye centred on its edges; both are sampled by clk.
`timescale 1ns/1ps
`include "dbsc_defs.vh"

// ----------------------------------------------------------------
// Signature compressor
// ----------------------------------------------------------------
module dbsc_misr #(
	parameter W = 14
) (
	input  wire          clk,
	input  wire          reset,
	input  wire          clear,
	input  wire          enable,
	input  wire          strobe,
	input  wire [W-1:0]  word,
	output reg  [31:0]   sig_reg
);
	wire        fb;
	wire [31:0] sig_next;

	// Taps 32,22,2,1: maximal length, easy to model in software
	assign fb       = sig_reg[31] ^ sig_reg[21] ^ sig_reg[1] ^ sig_reg[0];
	assign sig_next = {sig_reg[30:0], fb} ^ {{(32-W){1'b0}}, word};

	always @(posedge clk) begin
		if (reset || clear) begin
			sig_reg <= `DBSC_SIG_SEED;
		end else if (enable && strobe) begin
			sig_reg <= sig_next;
		end
	end
endmodule // dbsc_misr

// What this block does
// - Signatures come from fixed reproducible compression.
// - Clear bit high resets all accumulators.
// - Without interpolation FIFO signatures match input.
// - Interpolation mode signatures are undefined.
// - Bandgap trim field in trim bits 2:0.
// - Mirror roll-off select in trim bits 7:6.
// - Ten-bit full-scale code, resets to 0x200.
// - Gain is 72 plus 192/1024 times code.
// - Select bits pick one of four signatures.
// - One 32-bit compressor per phase, per stage.
// - Stage one after receivers, two after FIFO.
module dbsc_top #(
	parameter DW = 14
) (
	input  wire           clk,
	input  wire           reset,
	input  wire           spi_sclk,
	input  wire           spi_csb,
	input  wire           spi_sdi,
	output wire           spi_sdo,
	output wire           spi_sdo_oe,
	input  wire           forwarded_data_clock,
	input  wire [DW-1:0]  sample_word_in,
	input  wire           interp_2x,
	output wire [DW-1:0]  converter_word_p1,
	output wire [DW-1:0]  converter_word_p2,
	output wire           converter_valid,
	output wire [9:0]     full_scale_code,
	output wire [18:0]    full_scale_gain_q10,
	output wire [2:0]     bandgap_trim,
	output wire [1:0]     mirror_rolloff_select,
	output wire [7:0]     output_headroom
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	reg           sclk_s1_reg;
	reg           sclk_s2_reg;
	reg           sclk_s3_reg;
	reg           csb_s1_reg;
	reg           csb_s2_reg;
	reg           sdi_s1_reg;
	reg           sdi_s2_reg;
	reg           dclk_s1_reg;
	reg           dclk_s2_reg;
	reg           dclk_s3_reg;
	reg  [DW-1:0] data_s1_reg;
	reg  [DW-1:0] data_s2_reg;

	always @(posedge clk) begin
		if (reset) begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_s3_reg <= 1'b0;
			csb_s1_reg  <= 1'b1;
			csb_s2_reg  <= 1'b1;
			sdi_s1_reg  <= 1'b0;
			sdi_s2_reg  <= 1'b0;
			dclk_s1_reg <= 1'b0;
			dclk_s2_reg <= 1'b0;
			dclk_s3_reg <= 1'b0;
			data_s1_reg <= {DW{1'b0}};
			data_s2_reg <= {DW{1'b0}};
		end else begin
			sclk_s1_reg <= spi_sclk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_s3_reg <= sclk_s2_reg;
			csb_s1_reg  <= spi_csb;
			csb_s2_reg  <= csb_s1_reg;
			sdi_s1_reg  <= spi_sdi;
			sdi_s2_reg  <= sdi_s1_reg;
			dclk_s1_reg <= forwarded_data_clock;
			dclk_s2_reg <= dclk_s1_reg;
			dclk_s3_reg <= dclk_s2_reg;
			data_s1_reg <= sample_word_in;
			data_s2_reg <= data_s1_reg;
		end
	end

	wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
	wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
	// Data and clock share latency, so the word seen here was
	// sampled together with the detected edge
	wire in_stb_p1 = dclk_s2_reg & ~dclk_s3_reg;
	wire in_stb_p2 = ~dclk_s2_reg & dclk_s3_reg;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	reg  [7:0]  fsc_lo_reg;
	reg  [1:0]  fsc_hi_reg;
	reg  [7:0]  trim_reg;
	reg  [7:0]  hdrm_reg;
	reg  [7:0]  ctl_reg;
	reg  [18:0] gain_reg;
	wire        wr_stb;
	wire [7:0]  wr_data;
	reg  [4:0]  spi_addr_reg;
	wire [127:0] sig_all;
	wire [31:0] sig_sel;

	always @(posedge clk) begin
		if (reset) begin
			fsc_lo_reg <= `DBSC_RST_FSC_LO;
			fsc_hi_reg <= `DBSC_RST_FSC_HI;
			trim_reg   <= `DBSC_RST_TRIM;
			hdrm_reg   <= `DBSC_RST_HDRM;
			ctl_reg    <= `DBSC_RST_TEST_CTL;
		end else if (wr_stb) begin
			case (spi_addr_reg)
			`DBSC_ADDR_FSC_LO: begin
				fsc_lo_reg <= wr_data;
			end
			`DBSC_ADDR_FSC_HI: begin
				fsc_hi_reg <= wr_data[1:0];
			end
			`DBSC_ADDR_TRIM: begin
				// Bits 5:3 unused, read back as zero
				trim_reg <= wr_data & 8'hC7;
			end
			`DBSC_ADDR_HDRM: begin
				hdrm_reg <= wr_data;
			end
			`DBSC_ADDR_TEST_CTL: begin
				ctl_reg <= wr_data & 8'hC7;
			end
			default: begin
				ctl_reg <= ctl_reg;
			end
			endcase
		end
	end

	assign full_scale_code       = {fsc_hi_reg, fsc_lo_reg};
	assign bandgap_trim          = trim_reg[`DBSC_TRIM_BG_HI:0];
	assign mirror_rolloff_select =
		trim_reg[`DBSC_TRIM_MS_HI:`DBSC_TRIM_MS_LO];
	assign output_headroom       = hdrm_reg;

	// Gain scaled by 1024 so the fraction stays exact
	always @(posedge clk) begin
		if (reset) begin
			gain_reg <= `DBSC_RST_GAIN;
		end else begin
			gain_reg <= `DBSC_GAIN_BASE +
				`DBSC_GAIN_STEP * {9'h000, full_scale_code};
		end
	end
	assign full_scale_gain_q10 = gain_reg;

	wire ctl_clear   = ctl_reg[`DBSC_CTL_CLEAR];
	wire ctl_in_en   = ctl_reg[`DBSC_CTL_IN_EN];
	wire ctl_fifo_en = ctl_reg[`DBSC_CTL_FIFO_EN];
	wire [1:0] ctl_sel = ctl_reg[`DBSC_CTL_SEL_HI:`DBSC_CTL_SEL_LO];

	// Read data for the four signature bytes of the chosen compressor
	assign sig_sel = sig_all[{ctl_sel, 5'h00} +: 32];

	function [7:0] rd_mux;
		input [4:0] a;
		begin
			case (a)
			`DBSC_ADDR_FSC_LO:   rd_mux = fsc_lo_reg;
			`DBSC_ADDR_FSC_HI:   rd_mux = {6'h00, fsc_hi_reg};
			`DBSC_ADDR_TRIM:     rd_mux = trim_reg;
			`DBSC_ADDR_HDRM:     rd_mux = hdrm_reg;
			`DBSC_ADDR_TEST_CTL: rd_mux = ctl_reg;
			`DBSC_ADDR_SIG0:     rd_mux = sig_sel[7:0];
			`DBSC_ADDR_SIG1:     rd_mux = sig_sel[15:8];
			`DBSC_ADDR_SIG2:     rd_mux = sig_sel[23:16];
			`DBSC_ADDR_SIG3:     rd_mux = sig_sel[31:24];
			default:             rd_mux = 8'h00;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Serial port: R/W bit, two ignored bits, 5-bit address, data
	// ------------------------------------------------------------
	reg  [4:0] spi_cnt_reg;
	reg  [7:0] spi_sh_reg;
	reg        spi_rd_reg;
	reg  [7:0] spi_out_reg;
	reg        sdo_reg;
	reg        sdo_oe_reg;
	wire [7:0] spi_byte = {spi_sh_reg[6:0], sdi_s2_reg};

	always @(posedge clk) begin
		if (reset || csb_s2_reg) begin
			spi_cnt_reg  <= 5'h00;
			spi_sh_reg   <= 8'h00;
			spi_rd_reg   <= 1'b0;
			spi_out_reg  <= 8'h00;
			sdo_reg      <= 1'b0;
			sdo_oe_reg   <= 1'b0;
			if (reset) begin
				spi_addr_reg <= 5'h00;
			end
		end else begin
			if (sclk_rise && spi_cnt_reg != `DBSC_SPI_FRAME) begin
				spi_sh_reg  <= spi_byte;
				spi_cnt_reg <= spi_cnt_reg + 5'h01;
				if (spi_cnt_reg == 5'h07) begin
					spi_rd_reg   <= spi_byte[7];
					spi_addr_reg <= spi_byte[4:0];
					spi_out_reg  <= rd_mux(spi_byte[4:0]);
				end
			end
			if (sclk_fall && spi_rd_reg && spi_cnt_reg[3] &&
			    spi_cnt_reg != `DBSC_SPI_FRAME) begin
				sdo_reg     <= spi_out_reg[7];
				spi_out_reg <= {spi_out_reg[6:0], 1'b0};
				sdo_oe_reg  <= 1'b1;
			end
		end
	end

	assign wr_stb  = sclk_rise & ~csb_s2_reg & ~spi_rd_reg &
		(spi_cnt_reg == 5'h0F);
	assign wr_data = spi_byte;
	assign spi_sdo    = sdo_reg;
	assign spi_sdo_oe = sdo_oe_reg;

	// ------------------------------------------------------------
	// Clock-domain FIFO stage
	// ------------------------------------------------------------
	// One-deep retiming into the converter clock; the real part uses
	// a deeper FIFO, which only adds latency and leaves words intact.
	reg [DW-1:0] ff_p1_reg;
	reg [DW-1:0] ff_p2_reg;
	reg          ff_stb_p1_reg;
	reg          ff_stb_p2_reg;
	reg          ff_valid_reg;

	always @(posedge clk) begin
		if (reset) begin
			ff_p1_reg     <= {DW{1'b0}};
			ff_p2_reg     <= {DW{1'b0}};
			ff_stb_p1_reg <= 1'b0;
			ff_stb_p2_reg <= 1'b0;
			ff_valid_reg  <= 1'b0;
		end else begin
			ff_stb_p1_reg <= in_stb_p1;
			ff_valid_reg  <= in_stb_p2;
			if (in_stb_p1) begin
				ff_p1_reg <= data_s2_reg;
			end
			if (interp_2x) begin
				// Phase 2 repeats phase 1: the test has no meaning here
				ff_stb_p2_reg <= in_stb_p1;
				if (in_stb_p1) begin
					ff_p2_reg <= data_s2_reg;
				end
			end else begin
				ff_stb_p2_reg <= in_stb_p2;
				if (in_stb_p2) begin
					ff_p2_reg <= data_s2_reg;
				end
			end
		end
	end

	assign converter_word_p1 = ff_p1_reg;
	assign converter_word_p2 = ff_p2_reg;
	assign converter_valid   = ff_valid_reg;

	// ------------------------------------------------------------
	// Signature compressors: 0,1 input stage; 2,3 FIFO stage
	// ------------------------------------------------------------
	wire [3:0]      cmp_en  = {ctl_fifo_en, ctl_fifo_en,
		ctl_in_en, ctl_in_en};
	wire [3:0]      cmp_stb = {ff_stb_p2_reg, ff_stb_p1_reg,
		in_stb_p2, in_stb_p1};
	wire [4*DW-1:0] cmp_word = {ff_p2_reg, ff_p1_reg,
		data_s2_reg, data_s2_reg};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
			dbsc_misr #(
				.W (DW)
			) u_misr (
				.clk     (clk),
				.reset   (reset),
				.clear   (ctl_clear),
				.enable  (cmp_en[gi]),
				.strobe  (cmp_stb[gi]),
				.word    (cmp_word[gi*DW +: DW]),
				.sig_reg (sig_all[gi*32 +: 32])
			);
		end
	endgenerate

endmodule // dbsc_top

// ---- pkg/dbsc_defs.vh ----
// Constants for the self-test signature and analog control block.
// Assumes inclusion by bare name from core files; definitions only.
`ifndef DBSC_DEFS_VH
`define DBSC_DEFS_VH

// ----------------------------------------------------------------
// Register addresses (serial port, 5-bit address)
// ----------------------------------------------------------------
`define DBSC_ADDR_FSC_LO    5'h02
`define DBSC_ADDR_FSC_HI    5'h03
`define DBSC_ADDR_TRIM      5'h0E
`define DBSC_ADDR_HDRM      5'h0F
`define DBSC_ADDR_TEST_CTL  5'h11
`define DBSC_ADDR_SIG0      5'h12
`define DBSC_ADDR_SIG1      5'h13
`define DBSC_ADDR_SIG2      5'h14
`define DBSC_ADDR_SIG3      5'h15

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DBSC_CTL_CLEAR      0
`define DBSC_CTL_FIFO_EN    1
`define DBSC_CTL_IN_EN      2
`define DBSC_CTL_SEL_LO     6
`define DBSC_CTL_SEL_HI     7
`define DBSC_TRIM_BG_HI     2
`define DBSC_TRIM_MS_LO     6
`define DBSC_TRIM_MS_HI     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DBSC_RST_FSC        10'h200
`define DBSC_RST_FSC_LO     8'h00
`define DBSC_RST_FSC_HI     2'h2
`define DBSC_RST_GAIN       19'h2A000
`define DBSC_RST_TRIM       8'h00
`define DBSC_RST_HDRM       8'h00
`define DBSC_RST_TEST_CTL   8'h00
`define DBSC_SIG_SEED       32'h00000000

// ----------------------------------------------------------------
// Compressor and current scaling
// ----------------------------------------------------------------
`define DBSC_SIG_W          32
`define DBSC_GAIN_BASE      19'h12000
`define DBSC_GAIN_STEP      19'h000C0
`define DBSC_IDLE_UNSIGNED  14'h0000
`define DBSC_IDLE_TWOS      14'h2000
`define DBSC_IDLE_CYCLES    1024
`define DBSC_SPI_FRAME      5'h10

`endif

// ---- verif/dac_bist_signature_control_tb.sv ----
// Self-checking bench: serial register access and signature test flow.
// Assumes dbsc_top, dbsc_src and the bound checker are compiled first.
`timescale 1ns/1ps
`include "dbsc_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module dac_bist_signature_control_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        spi_sclk = 1'b0;
	logic        spi_csb = 1'b1;
	logic        spi_sdi = 1'b0;
	logic        interp_2x = 1'b0;
	wire         spi_sdo, spi_sdo_oe, forwarded_data_clock, converter_valid;
	wire  [13:0] sample_word_in, converter_word_p1, converter_word_p2;
	wire  [9:0]  full_scale_code;
	wire  [18:0] full_scale_gain_q10;
	wire  [2:0]  bandgap_trim;
	wire  [1:0]  mirror_rolloff_select;
	wire  [7:0]  output_headroom;
	int          failures = 0;
	int          tests_run = 0;
	logic [31:0] exp_sig [2];
	logic [31:0] sig;
	logic [13:0] w1, w2;
	logic [9:0]  code;
	logic [7:0]  rd, t;
	always #5 clk = ~clk;
	dbsc_top #(.DW(14)) dut (.*);
	dbsc_src src (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s,
		input logic [13:0] w);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]} ^ {18'h0, w};
	endfunction
	function automatic logic [18:0] gain(input logic [9:0] c);
		return 19'h12000 + 19'h000C0 * c;
	endfunction
	task automatic spi(input logic rw, input logic [4:0] a,
		input logic [7:0] d);
		logic [15:0] f;
		f = {rw, 2'b00, a, d};
		@(posedge clk) spi_csb <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_sclk <= 1'b0;
			spi_sdi <= f[i];
			repeat (6) @(posedge clk);
			@(negedge clk) rd[i % 8] = spi_sdo;
			if (rw && i < 8) `CHK("sdo_oe", 1'b1, spi_sdo_oe)
			@(posedge clk) spi_sclk <= 1'b1;
			repeat (6) @(posedge clk);
		end
		spi_sclk <= 1'b0;
		repeat (6) @(posedge clk);
		spi_csb <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task automatic read_sig;
		for (int b = 0; b < 4; b++) begin
			spi(1'b1, `DBSC_ADDR_SIG0 + 5'(b), 8'h00);
			sig[8*b +: 8] = rd;
		end
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'h6A58));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		spi(1'b1, `DBSC_ADDR_FSC_LO, 8'h00);
		`CHK("fsc_lo", 8'h00, rd)
		spi(1'b1, `DBSC_ADDR_FSC_HI, 8'h00);
		`CHK("fsc_hi", 8'h02, rd)
		spi(1'b1, 5'h1F, 8'h00);
		`CHK("unmapped", 8'h00, rd)
		for (int k = 0; k < 3; k++) begin
			code = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($urandom);
			spi(1'b0, `DBSC_ADDR_FSC_LO, code[7:0]);
			spi(1'b0, `DBSC_ADDR_FSC_HI, {6'h00, code[9:8]});
			`CHK("code", code, full_scale_code)
			`CHK("gain", gain(code), full_scale_gain_q10)
		end
		t = 8'($urandom);
		spi(1'b0, `DBSC_ADDR_TRIM, t);
		`CHK("bandgap", t[2:0], bandgap_trim)
		`CHK("rolloff", t[7:6], mirror_rolloff_select)
		spi(1'b1, `DBSC_ADDR_TRIM, 8'h00);
		`CHK("trim_rd", t & 8'hC7, rd)
		`CHK("headroom", `DBSC_RST_HDRM, output_headroom)
		spi(1'b1, `DBSC_ADDR_HDRM, 8'h00);
		`CHK("hdrm_rd", `DBSC_RST_HDRM, rd)
		src.idle(1024);
		spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'h06);
		spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'h07);
		spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'h06);
		exp_sig[0] = 32'h00000000;
		exp_sig[1] = 32'h00000000;
		for (int n = 0; n < 40; n++) begin
			w1 = (n == 0) ? 14'h3FFF : 14'($urandom);
			w2 = (n == 0) ? 14'h0000 : 14'($urandom);
			src.send(w1, w2);
			exp_sig[0] = lfsr(exp_sig[0], w1);
			exp_sig[1] = lfsr(exp_sig[1], w2);
		end
		src.rest;
		repeat (10) @(posedge clk);
		`CHK("word_p1", w1, converter_word_p1)
		`CHK("word_p2", w2, converter_word_p2)
		for (int s = 0; s < 4; s++) begin
			spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'(s << 6));
			read_sig;
			`CHK("signature", exp_sig[s % 2], sig)
		end
		src.send(14'($urandom), 14'($urandom));
		spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'h80);
		read_sig;
		`CHK("held_sig", exp_sig[0], sig)
		spi(1'b0, `DBSC_ADDR_TEST_CTL, 8'h01);
		read_sig;
		`CHK("cleared_sig", 32'h00000000, sig)
		@(posedge clk) interp_2x <= 1'b1;
		src.q = 40;
		w1 = 14'($urandom);
		src.send(w1, 14'($urandom));
		repeat (10) @(posedge clk);
		`CHK("dup_2x_p1", w1, converter_word_p1)
		`CHK("dup_2x_p2", w1, converter_word_p2)
		tally_and_finish;
	end
endmodule // dac_bist_signature_control_tb

// ---- verif/dbsc_asserts.sv ----
// Port-level checks for the signature and analog control block.
// Assumes binding onto dbsc_top; one clock domain, synchronous reset.
`timescale 1ns/1ps
module dbsc_asserts #(
	parameter DW = 14
) (
	input wire          clk,
	input wire          reset,
	input wire          spi_sclk,
	input wire          spi_csb,
	input wire          spi_sdi,
	input wire          spi_sdo,
	input wire          spi_sdo_oe,
	input wire          forwarded_data_clock,
	input wire [DW-1:0] sample_word_in,
	input wire          interp_2x,
	input wire [DW-1:0] converter_word_p1,
	input wire [DW-1:0] converter_word_p2,
	input wire          converter_valid,
	input wire [9:0]    full_scale_code,
	input wire [18:0]   full_scale_gain_q10,
	input wire [2:0]    bandgap_trim,
	input wire [1:0]    mirror_rolloff_select,
	input wire [7:0]    output_headroom
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_code_reset: assert property (disable iff (1'b0)
		reset |=> full_scale_code == 10'h200) else $error("code reset bad");
	a_trim_reset: assert property (disable iff (1'b0) reset |=>
		bandgap_trim == 3'h0 && mirror_rolloff_select == 2'h0)
		else $error("trim reset bad");
	a_gain_formula: assert property (full_scale_gain_q10 ==
		19'h12000 + 19'h000C0 * $past(full_scale_code)) else $error("gain bad");
	a_valid_spacing: assert property (
		converter_valid |=> !converter_valid [*6]) else $error("valid spacing");
	a_dup_in_2x: assert property (interp_2x && converter_valid |->
		converter_word_p2 == converter_word_p1) else $error("2x words differ");
	a_words_hold: assert property ($stable(forwarded_data_clock) [*7]
		|-> $stable(converter_word_p1) && $stable(converter_word_p2))
		else $error("words moved without link edge");
	a_oe_idle: assert property (
		spi_csb [*5] |-> !spi_sdo_oe) else $error("sdo driven outside frame");
	a_code_quiet: assert property (
		spi_csb [*8] |=> $stable(full_scale_code)) else $error("code moved");
	c_valid_1x: cover property (converter_valid && !interp_2x);
	c_valid_2x: cover property (converter_valid && interp_2x);
	c_read_oe: cover property ($rose(spi_sdo_oe));
endmodule // dbsc_asserts

bind dbsc_top dbsc_asserts #(.DW(DW)) u_chk (.*);

// ---- verif/dbsc_src.sv ----
// Sample source model: forwarded DDR clock plus data, 80 ns period.
// Assumes the bench calls its tasks; clock stands still between calls.
`timescale 1ns/1ps
`include "dbsc_defs.vh"
module dbsc_src (
	input  logic        clk,
	output logic        forwarded_data_clock,
	output logic [13:0] sample_word_in
);
	// Quarter period in ns; doubled when the rate is halved
	int q = 20;
	initial begin
		forwarded_data_clock = 1'b0;
		sample_word_in = `DBSC_IDLE_UNSIGNED;
	end
	// Changes land 3 ns after a clk rise, never on a sampling edge;
	// data moves a quarter period away from each link edge
	task automatic send(input logic [13:0] p1, input logic [13:0] p2);
		@(posedge clk);
		#3 sample_word_in = p1;
		#q forwarded_data_clock = 1'b1;
		#q sample_word_in = p2;
		#q forwarded_data_clock = 1'b0;
		#10;
	endtask
	// Last word held 20 ns past the final edge, then idle
	task automatic rest;
		#10 sample_word_in = `DBSC_IDLE_UNSIGNED;
	endtask
	task automatic idle(input int n);
		repeat (n) send(`DBSC_IDLE_UNSIGNED, `DBSC_IDLE_UNSIGNED);
	endtask
endmodule // dbsc_src
